// ### logic/ddrpi_sync2.v
// Two-flop synchroniser for a bus of pin inputs.
// Assumes each bit is an independent level from outside the core clock.
`timescale 1ns/10ps
module ddrpi_sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;
endmodule // ddrpi_sync2

// ### logic/ddrpi_top.v
// DDR SDRAM pin interface: forwarded clocks, command pins, DDR data path,
// per-bank clock enables with self-refresh and the receive-enable loop.
// Assumes user side on CORE_CLK; memory pins asynchronous to it.
`timescale 1ns/10ps
`include "ddrpi_map.vh"
module ddrpi_top #(
  parameter QTR    = `DDRPI_QTR_CYCLES,
  parameter CW     = 8,
  parameter RD_WIN = `DDRPI_RD_WIN
) (
  input  wire        CORE_CLK,
  input  wire        NRST,
  input  wire        CMD_VALID,
  output wire        CMD_READY,
  input  wire [2:0]  CMD_CODE,
  input  wire        CMD_CS,
  input  wire [1:0]  CMD_IBANK,
  input  wire [13:0] CMD_ADDR,
  input  wire [31:0] WR_DATA0,
  input  wire [31:0] WR_DATA1,
  input  wire [7:0]  WR_CHECK0,
  input  wire [7:0]  WR_CHECK1,
  input  wire        ECC_ENABLE,
  input  wire [1:0]  SREF_REQ,
  output wire [31:0] RD_DATA0,
  output wire [31:0] RD_DATA1,
  output wire [7:0]  RD_CHECK0,
  output wire [7:0]  RD_CHECK1,
  output wire        RD_VALID,
  output wire [2:0]  MEM_CLK_TRUE,
  output wire [2:0]  MEM_CLK_COMP,
  output wire [1:0]  BANK_SELECT_N,
  output wire        ROW_STROBE_N,
  output wire        COLUMN_STROBE_N,
  output wire        WRITE_STROBE_N,
  output wire [1:0]  INTERNAL_BANK_SEL,
  output wire [13:0] MEM_ADDR,
  output wire [4:0]  BYTE_MASK,
  input  wire [31:0] MEM_DATA_I,
  output wire [31:0] MEM_DATA_O,
  output wire        MEM_DATA_OE,
  input  wire [7:0]  CHECK_BYTE_I,
  output wire [7:0]  CHECK_BYTE_O,
  output wire        CHECK_BYTE_OE,
  input  wire [4:0]  DATA_STROBE_I,
  output wire [4:0]  DATA_STROBE_O,
  output wire        DATA_STROBE_OE,
  output wire [1:0]  BANK_CLK_ENABLE,
  output wire        RX_ENABLE_LOOP_OUT_N,
  input  wire        RX_ENABLE_LOOP_IN_N
);
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_CMD   = 2'h1;
  localparam [1:0] ST_WDATA = 2'h2;
  localparam [1:0] ST_RWAIT = 2'h3;
  localparam [CW-1:0] P_Q1   = QTR - 1;
  localparam [CW-1:0] P_FALL = 2 * QTR - 1;
  localparam [CW-1:0] P_Q3   = 3 * QTR - 1;
  localparam [CW-1:0] P_LAST = 4 * QTR - 1;
  localparam [3:0]    P_WIN  = RD_WIN - 1;
  reg [CW-1:0] cnt_reg;
  reg          clk_t_reg;
  reg          clk_c_reg;
  reg [1:0]    state_reg;
  reg [1:0]    cs_n_reg;
  reg [2:0]    enc_reg;
  reg [1:0]    ba_reg;
  reg [13:0]   addr_reg;
  reg [4:0]    mask_reg;
  reg [1:0]    cke_reg;
  reg [31:0]   dq_o_reg;
  reg          dq_oe_reg;
  reg [7:0]    cb_o_reg;
  reg [4:0]    dqs_o_reg;
  reg          rxo_n_reg;
  reg [3:0]    win_reg;
  reg          rd_pend_reg;
  reg          rd_valid_reg;
  reg [2:0]    code_reg;
  reg          ecc_w_reg;
  reg [31:0]   wd0_reg;
  reg [31:0]   wd1_reg;
  reg [7:0]    wc0_reg;
  reg [7:0]    wc1_reg;
  reg          rx_d_reg;
  reg [4:0]    dqs_d_reg;
  reg [7:0]    cap0_reg [0:4];
  reg [7:0]    cap1_reg [0:4];
  reg [2:0]    enc_next;
  wire [45:0] pin_s;
  wire [31:0] dq_s   = pin_s[31:0];
  wire [7:0]  cb_s   = pin_s[39:32];
  wire [4:0]  dqs_s  = pin_s[44:40];
  wire        rx_s_n = ~pin_s[45]; // Loop bit inverted so flop reset reads idle
  wire at_fall   = (cnt_reg == P_FALL);
  wire exit_any  = |(~SREF_REQ & ~cke_reg);
  wire enter_any = |(SREF_REQ & cke_reg);
  wire rx_rise   = rx_s_n & ~rx_d_reg;
  wire [1:0] cs_sel_n = CMD_CS ? 2'h1 : 2'h2;
  // Commands only to an awake bank, on a falling memory clock
  assign CMD_READY = (state_reg == ST_IDLE) & at_fall & ~exit_any & ~enter_any & cke_reg[CMD_CS];
  wire take = CMD_VALID & CMD_READY;
  always @* begin
    case (CMD_CODE)
      `DDRPI_CMD_ACT: enc_next = `DDRPI_ENC_ACT;
      `DDRPI_CMD_RD:  enc_next = `DDRPI_ENC_RD;
      `DDRPI_CMD_WR:  enc_next = `DDRPI_ENC_WR;
      `DDRPI_CMD_PRE: enc_next = `DDRPI_ENC_PRE;
      `DDRPI_CMD_REF: enc_next = `DDRPI_ENC_REF;
      `DDRPI_CMD_MRS: enc_next = `DDRPI_ENC_MRS;
      default:        enc_next = `DDRPI_ENC_NOP;
    endcase
  end
  ddrpi_sync2 #(
    .W (46)
  ) u_sync (
    .clk   (CORE_CLK),
    .rst_n (NRST),
    .d     ({~RX_ENABLE_LOOP_IN_N, DATA_STROBE_I, CHECK_BYTE_I, MEM_DATA_I}),
    .q     (pin_s)
  );
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_reg      <= {CW{1'b0}};
      clk_t_reg    <= 1'b0;
      clk_c_reg    <= 1'b1;
      state_reg    <= ST_IDLE;
      cs_n_reg     <= `DDRPI_RST_CS_N;
      enc_reg      <= `DDRPI_ENC_NOP;
      ba_reg       <= 2'h0;
      addr_reg     <= 14'h0000;
      mask_reg     <= `DDRPI_RST_MASK;
      cke_reg      <= `DDRPI_RST_CKE;
      dq_o_reg     <= 32'h00000000;
      dq_oe_reg    <= 1'b0;
      cb_o_reg     <= 8'h00;
      dqs_o_reg    <= 5'h00;
      rxo_n_reg    <= 1'b1;
      win_reg      <= 4'h0;
      rd_pend_reg  <= 1'b0;
      rd_valid_reg <= 1'b0;
      code_reg     <= `DDRPI_CMD_NOP;
      ecc_w_reg    <= 1'b0;
      wd0_reg      <= 32'h00000000;
      wd1_reg      <= 32'h00000000;
      wc0_reg      <= 8'h00;
      wc1_reg      <= 8'h00;
      rx_d_reg     <= 1'b1;
      dqs_d_reg    <= 5'h00;
    end else begin
      // Forwarded clock: high for first half of each period
      cnt_reg   <= (cnt_reg == P_LAST) ? {CW{1'b0}} : cnt_reg + 1'b1;
      clk_t_reg <= (cnt_reg == P_LAST) | (cnt_reg < P_FALL);
      clk_c_reg <= ~((cnt_reg == P_LAST) | (cnt_reg < P_FALL));
      rx_d_reg  <= rx_s_n;
      dqs_d_reg <= dqs_s;
      rd_valid_reg <= rx_rise & rd_pend_reg;
      if (rx_rise) begin
        rd_pend_reg <= 1'b0;
      end
      if (state_reg == ST_WDATA) begin
        if (cnt_reg == P_LAST) begin
          dq_o_reg <= wd1_reg;
          cb_o_reg <= wc1_reg;
        end
        if (cnt_reg == P_Q3) begin
          dqs_o_reg <= 5'h1f;
        end
        if (cnt_reg == P_Q1) begin
          dqs_o_reg <= 5'h00;
        end
      end
      if (at_fall) begin
        cs_n_reg <= 2'h3;
        enc_reg  <= `DDRPI_ENC_NOP;
        case (state_reg)
          ST_IDLE: begin
            if (exit_any) begin
              cke_reg <= cke_reg | ~SREF_REQ;
            end else if (enter_any) begin
              // Self-refresh entry: refresh with enable dropped
              cs_n_reg <= ~(SREF_REQ & cke_reg);
              enc_reg  <= `DDRPI_ENC_REF;
              cke_reg  <= cke_reg & ~SREF_REQ;
            end else if (take) begin
              cs_n_reg  <= cs_sel_n;
              enc_reg   <= enc_next;
              ba_reg    <= CMD_IBANK;
              addr_reg  <= CMD_ADDR;
              code_reg  <= CMD_CODE;
              ecc_w_reg <= ECC_ENABLE;
              wd0_reg   <= WR_DATA0;
              wd1_reg   <= WR_DATA1;
              wc0_reg   <= WR_CHECK0;
              wc1_reg   <= WR_CHECK1;
              state_reg <= ST_CMD;
              if (CMD_CODE == `DDRPI_CMD_RD) begin
                rd_pend_reg <= 1'b1;
              end
            end
          end
          ST_CMD: begin
            if (code_reg == `DDRPI_CMD_WR) begin
              dq_o_reg  <= wd0_reg;
              cb_o_reg  <= wc0_reg;
              dq_oe_reg <= 1'b1;
              dqs_o_reg <= 5'h00;
              mask_reg  <= {~ecc_w_reg, 4'h0};
              state_reg <= ST_WDATA;
            end else if (code_reg == `DDRPI_CMD_RD) begin
              rxo_n_reg <= 1'b0;
              win_reg   <= P_WIN;
              state_reg <= ST_RWAIT;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
          ST_WDATA: begin
            dq_oe_reg <= 1'b0;
            state_reg <= ST_IDLE;
          end
          ST_RWAIT: begin
            if (win_reg == 4'h0) begin
              rxo_n_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end else begin
              win_reg <= win_reg - 1'b1;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end
  // Per-lane capture on both strobe edges while receivers enabled
  genvar gl;
  generate
    for (gl = 0; gl < 5; gl = gl + 1) begin : g_lane
      wire [7:0] lane_s = (gl == 4) ? cb_s : dq_s[8*(gl%4)+7:8*(gl%4)];
      always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
          cap0_reg[gl] <= 8'h00;
          cap1_reg[gl] <= 8'h00;
        end else if (!rx_s_n) begin
          if (dqs_s[gl] & ~dqs_d_reg[gl]) begin
            cap0_reg[gl] <= lane_s;
          end
          if (~dqs_s[gl] & dqs_d_reg[gl]) begin
            cap1_reg[gl] <= lane_s;
          end
        end
      end
    end
  endgenerate
  assign RD_DATA0          = {cap0_reg[3], cap0_reg[2], cap0_reg[1], cap0_reg[0]};
  assign RD_DATA1          = {cap1_reg[3], cap1_reg[2], cap1_reg[1], cap1_reg[0]};
  assign RD_CHECK0         = cap0_reg[4];
  assign RD_CHECK1         = cap1_reg[4];
  assign RD_VALID          = rd_valid_reg;
  assign MEM_CLK_TRUE      = {3{clk_t_reg}};
  assign MEM_CLK_COMP      = {3{clk_c_reg}};
  assign BANK_SELECT_N     = cs_n_reg;
  assign ROW_STROBE_N      = enc_reg[2];
  assign COLUMN_STROBE_N   = enc_reg[1];
  assign WRITE_STROBE_N    = enc_reg[0];
  assign INTERNAL_BANK_SEL = ba_reg;
  assign MEM_ADDR          = addr_reg;
  assign BYTE_MASK         = mask_reg;
  assign MEM_DATA_O        = dq_o_reg;
  assign MEM_DATA_OE       = dq_oe_reg;
  assign CHECK_BYTE_O      = cb_o_reg;
  assign CHECK_BYTE_OE     = dq_oe_reg & ecc_w_reg;
  assign DATA_STROBE_O     = dqs_o_reg;
  assign DATA_STROBE_OE    = dq_oe_reg;
  assign BANK_CLK_ENABLE   = cke_reg;
  assign RX_ENABLE_LOOP_OUT_N = rxo_n_reg;
endmodule // ddrpi_top

// ### shared/ddrpi_map.vh
// Constants for the DDR SDRAM pin interface: command codes, pin encodings,
// reset values and memory-clock timing.
// Assumes inclusion by bare name from the design files.
`ifndef DDRPI_MAP_VH
`define DDRPI_MAP_VH

// Core clock period in ns
`define DDRPI_CORE_PERIOD_NS 4
// Core cycles per quarter of a memory clock period
`define DDRPI_QTR_CYCLES 4
// Memory clocks the receive-enable loop stays asserted after a read
`define DDRPI_RD_WIN 3

// User command codes
`define DDRPI_CMD_NOP  3'h0
`define DDRPI_CMD_ACT  3'h1
`define DDRPI_CMD_RD   3'h2
`define DDRPI_CMD_WR   3'h3
`define DDRPI_CMD_PRE  3'h4
`define DDRPI_CMD_REF  3'h5
`define DDRPI_CMD_MRS  3'h6

// Pin encodings {row_strobe_n, column_strobe_n, write_strobe_n}
`define DDRPI_ENC_NOP  3'h7
`define DDRPI_ENC_ACT  3'h3
`define DDRPI_ENC_RD   3'h5
`define DDRPI_ENC_WR   3'h4
`define DDRPI_ENC_PRE  3'h2
`define DDRPI_ENC_REF  3'h1
`define DDRPI_ENC_MRS  3'h0

// Reset values
`define DDRPI_RST_CS_N  2'h3
`define DDRPI_RST_CKE   2'h3
`define DDRPI_RST_MASK  5'h00

`endif

// ### sim/ddrpi_checker.sv
// Checker for the DDR pin interface pin outputs.
// Assumes binding to ddrpi_top and the command encodings of the map header.
`timescale 1ns/10ps
module ddrpi_checker #(
  parameter int QTR = 4
) (
  input wire       CORE_CLK,
  input wire       NRST,
  input wire [2:0] MEM_CLK_TRUE,
  input wire [2:0] MEM_CLK_COMP,
  input wire [1:0] BANK_SELECT_N,
  input wire       ROW_STROBE_N,
  input wire       COLUMN_STROBE_N,
  input wire       WRITE_STROBE_N,
  input wire [4:0] BYTE_MASK,
  input wire       MEM_DATA_OE,
  input wire       CHECK_BYTE_OE,
  input wire       DATA_STROBE_OE,
  input wire [4:0] DATA_STROBE_O,
  input wire [1:0] BANK_CLK_ENABLE,
  input wire       RX_ENABLE_LOOP_OUT_N,
  input wire       RX_ENABLE_LOOP_IN_N,
  input wire       RD_VALID
);
  localparam int PER = 4 * QTR;
  localparam int PM1 = PER - 1;
  wire [2:0] enc     = {ROW_STROBE_N, COLUMN_STROBE_N, WRITE_STROBE_N};
  wire       any_sel = BANK_SELECT_N != 2'h3;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  clk_pair_a: assert property (MEM_CLK_COMP == ~MEM_CLK_TRUE && MEM_CLK_TRUE inside {3'h0, 3'h7})
    else $error("Clock pairs differ");
  one_bank_a: assert property (BANK_SELECT_N != 2'h0)
    else $error("Both selects low");
  full_width_a: assert property (BYTE_MASK[3:0] == 4'h0)
    else $error("Data byte masked");
  sref_entry_a: assert property ($fell(BANK_CLK_ENABLE[0]) |-> !BANK_SELECT_N[0] && enc == 3'h1)
    else $error("Enable dropped without refresh");
  cmd_stand_a: assert property ($fell(BANK_SELECT_N[1]) |-> ##PM1 !BANK_SELECT_N[1])
    else $error("Select released early");
  wr_data_a: assert property (any_sel && enc == 3'h4 |-> ##PER MEM_DATA_OE)
    else $error("Write data not driven");
  rd_loop_a: assert property (any_sel && enc == 3'h5 |-> ##PER !RX_ENABLE_LOOP_OUT_N && !MEM_DATA_OE)
    else $error("Read loop not opened");
  check_oe_a: assert property (CHECK_BYTE_OE |-> MEM_DATA_OE && !BYTE_MASK[4])
    else $error("Check byte driven alone");
  strobe_oe_a: assert property (DATA_STROBE_OE == MEM_DATA_OE)
    else $error("Strobe enable differs");
  strobe_pre_a: assert property ($rose(DATA_STROBE_OE) |-> DATA_STROBE_O == 5'h00)
    else $error("Strobe not low at write start");
  rd_done_a: assert property ($rose(RX_ENABLE_LOOP_IN_N) |-> ##[1:6] RD_VALID)
    else $error("Read data not delivered");
  cover property (any_sel && enc == 3'h4);
  cover property (RD_VALID);
  cover property ($fell(BANK_CLK_ENABLE[0]));
endmodule // ddrpi_checker
bind ddrpi_top ddrpi_checker #(.QTR(QTR)) u_chk (
  .CORE_CLK             (CORE_CLK),
  .NRST                 (NRST),
  .MEM_CLK_TRUE         (MEM_CLK_TRUE),
  .MEM_CLK_COMP         (MEM_CLK_COMP),
  .BANK_SELECT_N        (BANK_SELECT_N),
  .ROW_STROBE_N         (ROW_STROBE_N),
  .COLUMN_STROBE_N      (COLUMN_STROBE_N),
  .WRITE_STROBE_N       (WRITE_STROBE_N),
  .BYTE_MASK            (BYTE_MASK),
  .MEM_DATA_OE          (MEM_DATA_OE),
  .CHECK_BYTE_OE        (CHECK_BYTE_OE),
  .DATA_STROBE_OE       (DATA_STROBE_OE),
  .DATA_STROBE_O        (DATA_STROBE_O),
  .BANK_CLK_ENABLE      (BANK_CLK_ENABLE),
  .RX_ENABLE_LOOP_OUT_N (RX_ENABLE_LOOP_OUT_N),
  .RX_ENABLE_LOOP_IN_N  (RX_ENABLE_LOOP_IN_N),
  .RD_VALID             (RD_VALID)
);

// ### sim/ddrpi_mem_model.sv
// Behavioural memory at the pin side: answers reads on both strobe edges.
// Assumes a 10 ns loop trace and 62.5 ns strobe half period.
`timescale 1ns/10ps
module ddrpi_mem_model (
  input  wire [2:0]  MEM_CLK_TRUE,
  input  wire [1:0]  BANK_SELECT_N,
  input  wire        ROW_STROBE_N,
  input  wire        COLUMN_STROBE_N,
  input  wire        WRITE_STROBE_N,
  input  wire [13:0] MEM_ADDR,
  input  wire [1:0]  BANK_CLK_ENABLE,
  input  wire        RX_ENABLE_LOOP_OUT_N,
  output reg  [31:0] MEM_DATA_I,
  output reg  [7:0]  CHECK_BYTE_I,
  output reg  [4:0]  DATA_STROBE_I,
  output wire        RX_ENABLE_LOOP_IN_N
);
  reg [13:0] col_reg = 14'h0000;
  assign #10 RX_ENABLE_LOOP_IN_N = RX_ENABLE_LOOP_OUT_N;
  initial begin
    MEM_DATA_I = 32'h00000000;
    CHECK_BYTE_I = 8'h00;
    DATA_STROBE_I = 5'h00;
  end
  // Column latched on rising clock, sleeping bank ignored
  always @(posedge MEM_CLK_TRUE[0]) begin
    if ((~BANK_SELECT_N & BANK_CLK_ENABLE) != 2'h0 &&
        {ROW_STROBE_N, COLUMN_STROBE_N, WRITE_STROBE_N} == 3'h5)
      col_reg <= MEM_ADDR;
  end
  // Beat 0 on rising strobe, beat 1 on falling; all lanes together
  always @(negedge RX_ENABLE_LOOP_IN_N) begin
    #15 MEM_DATA_I = {18'h00000, col_reg};
    CHECK_BYTE_I = col_reg[7:0];
    #20 DATA_STROBE_I = 5'h1f;
    #42.5 MEM_DATA_I = ~{18'h00000, col_reg};
    CHECK_BYTE_I = ~col_reg[7:0];
    #20 DATA_STROBE_I = 5'h00;
  end
  // Released data shows inverse; strobe parks at its terminated level
  always @(posedge RX_ENABLE_LOOP_IN_N) begin
    MEM_DATA_I = ~MEM_DATA_I;
    CHECK_BYTE_I = ~CHECK_BYTE_I;
  end
endmodule // ddrpi_mem_model

// ### sim/ddrpi_top_tb.sv
// Testbench for the DDR pin interface: commands, bursts, self refresh.
// Assumes the memory model on the pin side, loop delay within the window.
`timescale 1ns/10ps
module ddrpi_top_tb;
  localparam QTR = 4;
  localparam PER = 4 * QTR;
  localparam [20:0] ENC = 21'h1dd888;
  reg         CORE_CLK = 1'b0, NRST = 1'b0, CMD_VALID = 1'b0, CMD_CS = 1'b0, ECC_ENABLE = 1'b0;
  reg  [2:0]  CMD_CODE = 3'h0;
  reg  [1:0]  CMD_IBANK = 2'h0, SREF_REQ = 2'h0;
  reg  [13:0] CMD_ADDR = 14'h0000;
  reg  [31:0] WR_DATA0 = 32'h0a1b2c3d, WR_DATA1 = 32'hf4e5d6c7;
  reg  [7:0]  WR_CHECK0 = 8'h5e, WR_CHECK1 = 8'ha1;
  wire        CMD_READY, RD_VALID, ROW_STROBE_N, COLUMN_STROBE_N, WRITE_STROBE_N;
  wire        MEM_DATA_OE, CHECK_BYTE_OE, DATA_STROBE_OE, RX_ENABLE_LOOP_OUT_N, RX_ENABLE_LOOP_IN_N;
  wire [31:0] RD_DATA0, RD_DATA1, MEM_DATA_I, MEM_DATA_O;
  wire [7:0]  RD_CHECK0, RD_CHECK1, CHECK_BYTE_I, CHECK_BYTE_O;
  wire [2:0]  MEM_CLK_TRUE, MEM_CLK_COMP;
  wire [1:0]  BANK_SELECT_N, INTERNAL_BANK_SEL, BANK_CLK_ENABLE;
  wire [13:0] MEM_ADDR;
  wire [4:0]  BYTE_MASK, DATA_STROBE_I, DATA_STROBE_O;
  wire [2:0]  enc = {ROW_STROBE_N, COLUMN_STROBE_N, WRITE_STROBE_N};
  integer     num_errors = 0, checks_done = 0, cyc = 0, i;
  ddrpi_top #(.QTR(QTR)) u_dut (.*);
  ddrpi_mem_model u_mem (.*);
  always #2 CORE_CLK = ~CORE_CLK;
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task end_sim;
    begin
      if (num_errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  always @(posedge CORE_CLK) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      num_errors = num_errors + 1;
      end_sim;
    end
  end
  task wait_neg(input integer n);
    repeat (n) @(negedge CORE_CLK);
  endtask
  task cmd(input [2:0] c, input cs, input [13:0] a, input ecc);
    integer n;
    begin
      n = 0;
      @(posedge CORE_CLK);
      CMD_VALID <= 1'b1;
      CMD_CODE <= c;
      CMD_CS <= cs;
      CMD_IBANK <= a[1:0];
      CMD_ADDR <= a;
      ECC_ENABLE <= ecc;
      @(negedge CORE_CLK);
      while (CMD_READY !== 1'b1 && n < 200) begin
        @(negedge CORE_CLK);
        n = n + 1;
      end
      @(posedge CORE_CLK);
      CMD_VALID <= 1'b0;
      @(negedge CORE_CLK);
      chk(BANK_SELECT_N, cs ? 2'h1 : 2'h2);
      chk(INTERNAL_BANK_SEL, a[1:0]);
      chk(MEM_ADDR, a);
      chk(enc, ENC[20-3*c -: 3]);
      chk(MEM_CLK_TRUE, 3'h0);
    end
  endtask
  task t_reset;
    begin
      chk({BANK_SELECT_N, BANK_CLK_ENABLE, MEM_CLK_COMP, MEM_CLK_TRUE}, 10'h3f8);
      chk({BYTE_MASK, MEM_DATA_OE, RX_ENABLE_LOOP_OUT_N}, 7'h01);
    end
  endtask
  task t_write(input ecc);
    begin
      cmd(3'h3, 1'b0, {13'h0091, ecc}, ecc);
      wait_neg(PER);
      chk({BANK_SELECT_N, MEM_DATA_OE, CHECK_BYTE_OE, DATA_STROBE_OE}, {3'h7, ecc, 1'b1});
      chk(BYTE_MASK, {~ecc, 4'h0});
      chk({MEM_DATA_O, CHECK_BYTE_O, DATA_STROBE_O}, {WR_DATA0, WR_CHECK0, 5'h00});
      wait_neg(QTR + 2);
      chk(DATA_STROBE_O, 5'h1f);
      wait_neg(QTR);
      chk({MEM_DATA_O, CHECK_BYTE_O}, {WR_DATA1, WR_CHECK1});
    end
  endtask
  task t_read;
    integer n;
    begin
      n = 0;
      cmd(3'h2, 1'b1, 14'h2a56, 1'b1);
      while (RD_VALID !== 1'b1 && n < 400) begin
        @(negedge CORE_CLK);
        n = n + 1;
      end
      chk({RD_DATA0, RD_CHECK0}, {32'h00002a56, 8'h56});
      chk({RD_DATA1, RD_CHECK1}, {32'hffffd5a9, 8'ha9});
    end
  endtask
  task t_sref;
    integer n;
    reg     refused;
    begin
      n = 0;
      @(posedge CORE_CLK);
      SREF_REQ <= 2'h1;
      while (BANK_CLK_ENABLE[0] !== 1'b0 && n < 100) begin
        @(negedge CORE_CLK);
        n = n + 1;
      end
      chk({BANK_CLK_ENABLE, BANK_SELECT_N, enc}, 7'h51);
      // Sleeping bank must never be offered a command slot
      @(posedge CORE_CLK);
      CMD_CS <= 1'b0;
      refused = 1'b1;
      repeat (PER + 1) begin
        @(negedge CORE_CLK);
        if (CMD_READY !== 1'b0) refused = 1'b0;
      end
      chk(refused, 1'b1);
      cmd(3'h1, 1'b1, 14'h0005, 1'b0);
      chk(BANK_CLK_ENABLE, 2'h2);
      @(posedge CORE_CLK);
      SREF_REQ <= 2'h0;
      while (BANK_CLK_ENABLE !== 2'h3 && n < 300) begin
        @(negedge CORE_CLK);
        n = n + 1;
      end
      chk(BANK_CLK_ENABLE, 2'h3);
    end
  endtask
  initial begin
    wait_neg(3);
    t_reset;
    repeat (3) @(posedge CORE_CLK);
    NRST <= 1'b1;
    for (i = 0; i < 7; i = i + 1)
      if (i != 2 && i != 3) cmd(i[2:0], 1'b0, 14'h1000 + i[13:0], 1'b1);
    t_write(1'b1);
    t_write(1'b0);
    t_read;
    t_sref;
    end_sim;
  end
endmodule // ddrpi_top_tb
